// [rtl/ppdc_top.sv]
// Contract
// [RL1] Each pin has a three-bit drive mode field.
// [RL2] Modes 0 and 1 never drive the pin.
// [RL3] Modes 2 and 3: resistive half, strong half.
// [RL4] Mode 4 drives low, releases high.
// [RL5] Mode 5 drives high, releases low.
// [RL6] Mode 6 drives strongly both ways.
// [RL7] Mode 7 pulls up or down always.
// [RL8] No resistors on regulated special pins.
// [RL9] Output data from register or bypass signal.
// [RL10] Pin state read apart from data write.
// [RL11] Rising, falling or both edge interrupts.
// [RL12] One interrupt vector for this port.
// [RL13] Programmable reset drive state per port.
// [RL14] Settings reachable per port and per pin. Edge enables and output-enable line selects are written in port form only.
// [RL15] Processor, DMA and peripherals use pins.
// [RL16] Slow slew option for digital drive.
// [RL17] Transceiver pins push-pull only, interrupts kept.
// [RL18] Analog mode disables the digital input.
// [RL19] Routed output enable toggles bidirectional pins.
// [RL20] Decode mode and data to pad controls.
`timescale 1ns/1ns
module ppdc_top
  import ppdc_pkg::*;
#(
  parameter int         N_PINS      = PPDC_PINS,
  parameter logic [7:0] RESET_DM0   = PPDC_RST_DM,
  parameter logic [7:0] RESET_DM1   = PPDC_RST_DM,
  parameter logic [7:0] RESET_DM2   = PPDC_RST_DM,
  parameter logic [7:0] SPECIAL_MSK = 8'h00,
  parameter logic [7:0] XCVR_MSK    = 8'h00
)(
  input  wire logic                     clk_i,
  input  wire logic                     rst_b_i,
  input  wire logic [PPDC_AW-1:0]       avs_address_i,
  input  wire logic                     avs_read_i,
  input  wire logic                     avs_write_i,
  input  wire logic [PPDC_DW-1:0]       avs_writedata_i,
  output logic      [PPDC_DW-1:0]       avs_readdata_o,
  output logic                          avs_waitrequest_o,
  input  wire logic [N_PINS-1:0]        pad_in_i,
  output logic      [N_PINS-1:0]        pad_out_o,
  output logic      [N_PINS-1:0]        pad_oe_o,
  output logic      [N_PINS-1:0]        pad_pull_up_o,
  output logic      [N_PINS-1:0]        pad_pull_dn_o,
  output logic      [N_PINS-1:0]        pad_slow_o,
  input  wire logic [N_PINS-1:0]        dsi_out_i,
  input  wire logic [PPDC_OE_LINES-1:0] oe_bus_i,
  output logic      [N_PINS-1:0]        dsi_in_o,
  output logic                          irq_o
);

  // ------------------------------------------------------------------
  // Configuration and state
  // ------------------------------------------------------------------
  logic [7:0]  data_reg;
  logic [7:0]  dm0;
  logic [7:0]  dm1;
  logic [7:0]  dm2;
  logic [7:0]  byp;
  logic [7:0]  bie;
  logic [7:0]  slw;
  logic [7:0]  regout;
  logic [7:0]  int_rise;
  logic [7:0]  int_fall;
  logic [7:0]  int_stat;
  logic [31:0] oesel;
  logic [7:0]  pin_state;
  logic [7:0]  pin_prev;
  logic        ack;

  // ------------------------------------------------------------------
  // Avalon-MM slave handshake
  // ------------------------------------------------------------------
  logic       req;
  logic       wr_go;
  logic       port_wr;
  logic       pin_wr;
  logic [2:0] pin_idx;
  logic [7:0] wbyte;

  // Every access costs one wait cycle, which gives read data a full cycle
  // to settle from a registered mux instead of a long combinational path.
  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack;
  assign wr_go             = avs_write_i & ack;
  assign pin_wr            = wr_go && (avs_address_i[7:5] == PPDC_PIN_PAGE);
  assign port_wr           = wr_go && (avs_address_i[7:5] != PPDC_PIN_PAGE);
  assign pin_idx           = avs_address_i[4:2];
  assign wbyte             = avs_writedata_i[7:0];

  // Acknowledge one cycle after a request appears, then drop for a cycle.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // ------------------------------------------------------------------
  // Write helper shared by every per-pin field that has a pin form
  // ------------------------------------------------------------------
  // Merges a port-form byte write and a pin-form bit write into one field.
  function automatic logic [7:0] ppdc_merge(input logic [7:0] cur,
                                            input logic [7:0] off,
                                            input int         pos);
    logic [7:0] nv;
    nv = cur;
    if (port_wr && avs_address_i == off) begin
      nv = wbyte;
    end
    if (pin_wr && pin_idx < N_PINS) begin
      nv[pin_idx] = avs_writedata_i[pos];
    end
    return nv;
  endfunction

  // ------------------------------------------------------------------
  // Output data register
  // ------------------------------------------------------------------
  // Writes land here only; the pin state is a separate register.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_reg <= PPDC_RST_BYTE;
    end else begin
      data_reg <= ppdc_merge(data_reg, PPDC_OFF_DATA, PPDC_PF_DR); // see [RL10] see [RL14] see [RL15]
    end
  end

  // ------------------------------------------------------------------
  // Drive mode bits
  // ------------------------------------------------------------------
  // Reset values come from parameters so each port has its own state.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dm0 <= RESET_DM0; // see [RL13]
      dm1 <= RESET_DM1;
      dm2 <= RESET_DM2;
    end else begin
      dm0 <= ppdc_merge(dm0, PPDC_OFF_DM0, PPDC_PF_DM); // see [RL1] see [RL14]
      dm1 <= ppdc_merge(dm1, PPDC_OFF_DM1, PPDC_PF_DM + 1);
      dm2 <= ppdc_merge(dm2, PPDC_OFF_DM2, PPDC_PF_DM + 2);
    end
  end

  // ------------------------------------------------------------------
  // Bypass, bidirectional, slew and regulated-level selects
  // ------------------------------------------------------------------
  // These four fields share one merge helper and one reset value; regout keeps only the bits set in SPECIAL_MSK.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      byp    <= PPDC_RST_BYTE;
      bie    <= PPDC_RST_BYTE;
      slw    <= PPDC_RST_BYTE;
      regout <= PPDC_RST_BYTE;
    end else begin
      byp    <= ppdc_merge(byp, PPDC_OFF_BYP, PPDC_PF_BYP);
      bie    <= ppdc_merge(bie, PPDC_OFF_BIE, PPDC_PF_BIE);
      slw    <= ppdc_merge(slw, PPDC_OFF_SLW, PPDC_PF_SLW);
      regout <= ppdc_merge(regout, PPDC_OFF_REGOUT, PPDC_PF_REG) & SPECIAL_MSK;
    end
  end

  // ------------------------------------------------------------------
  // Interrupt type and output-enable line selection
  // ------------------------------------------------------------------
  // Edge enables and line selects are written in port form only.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_rise <= PPDC_RST_BYTE;
      int_fall <= PPDC_RST_BYTE;
      oesel    <= PPDC_RST_OESEL;
    end else if (port_wr) begin
      if (avs_address_i == PPDC_OFF_INTRISE) begin
        int_rise <= wbyte; // see [RL11]
      end
      if (avs_address_i == PPDC_OFF_INTFALL) begin
        int_fall <= wbyte;
      end
      if (avs_address_i == PPDC_OFF_OESEL) begin
        oesel <= avs_writedata_i;
      end
    end
  end

  // ------------------------------------------------------------------
  // Pin state sampling
  // ------------------------------------------------------------------
  logic [7:0] in_en;
  logic [7:0] pad_in8;

  assign pad_in8 = 8'(pad_in_i);

  // Analog pins read as zero so a floating level never looks like data.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_state <= PPDC_RST_BYTE;
      pin_prev  <= PPDC_RST_BYTE;
    end else begin
      pin_state <= pad_in8 & in_en; // see [RL18] see [RL10]
      pin_prev  <= pin_state;
    end
  end

  assign dsi_in_o = pin_state[N_PINS-1:0]; // see [RL15]

  // ------------------------------------------------------------------
  // Edge interrupt status
  // ------------------------------------------------------------------
  logic [7:0] edge_hit;
  logic [7:0] stat_clr;

  // Level detection is left to routed logic; only edges raise status.
  assign edge_hit = (pin_state & ~pin_prev & int_rise) |
                    (~pin_state & pin_prev & int_fall); // see [RL11] see [RL17]
  assign stat_clr = (port_wr && avs_address_i == PPDC_OFF_INTSTAT) ? wbyte : 8'h00;

  // Write one to clear; an edge in the clearing cycle still sets the bit.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_stat <= PPDC_RST_BYTE;
    end else begin
      int_stat <= (int_stat & ~stat_clr) | edge_hit;
    end
  end

  // The whole port shares one request line toward the controller.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |((int_stat & ~stat_clr) | edge_hit); // see [RL12]
    end
  end

  // ------------------------------------------------------------------
  // Per-pin drivers
  // ------------------------------------------------------------------
  logic [7:0] out_val;
  logic [7:0] oe_sel;
  logic [7:0] d_hi;
  logic [7:0] d_lo;
  logic [7:0] p_up;
  logic [7:0] p_dn;
  logic [7:0] slow;

  for (genvar g = 0; g < 8; g++) begin : g_pin
    // Bypass hands the pin to the routed peripheral signal.
    assign out_val[g] = (g < N_PINS && byp[g]) ? dsi_out_i[g % N_PINS] : data_reg[g]; // see [RL9]
    assign oe_sel[g]  = oe_bus_i[oesel[g*PPDC_OESEL_W +: PPDC_OESEL_W]]; // see [RL19]

    ppdc_pin_drive u_drv (
      .mode_i     ({dm2[g], dm1[g], dm0[g]}),
      .data_i     (out_val[g]),
      .bie_i      (bie[g]),
      .oe_i       (oe_sel[g]),
      .special_i  (SPECIAL_MSK[g]),
      .regout_i   (regout[g]),
      .xcvr_i     (XCVR_MSK[g]),
      .drive_hi_o (d_hi[g]),
      .drive_lo_o (d_lo[g]),
      .pull_up_o  (p_up[g]),
      .pull_dn_o  (p_dn[g]),
      .in_en_o    (in_en[g])
    );

    // Slow edges apply to drive in modes 4, 5 and 6 only, not to resistive modes; transceiver pins stay fast.
    assign slow[g] = slw[g] & (d_hi[g] | d_lo[g]) & ~XCVR_MSK[g] &
                     ~ppdc_is_resistive({dm2[g], dm1[g], dm0[g]}); // see [RL16]
  end

  // Pad controls are registered so glitches from the decode never reach a pin.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pad_out_o     <= '0;
      pad_oe_o      <= '0;
      pad_pull_up_o <= '0;
      pad_pull_dn_o <= '0;
      pad_slow_o    <= '0;
    end else begin
      pad_out_o     <= d_hi[N_PINS-1:0]; // see [RL20]
      pad_oe_o      <= d_hi[N_PINS-1:0] | d_lo[N_PINS-1:0];
      pad_pull_up_o <= p_up[N_PINS-1:0];
      pad_pull_dn_o <= p_dn[N_PINS-1:0];
      pad_slow_o    <= slow[N_PINS-1:0];
    end
  end

  // ------------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------------
  logic [31:0] next_rdata;

  // Pin-form words gather the eight most used bits of one pin.
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (avs_address_i[7:5] == PPDC_PIN_PAGE) begin
      if (pin_idx < N_PINS) begin
        next_rdata[PPDC_PF_DR]        = data_reg[pin_idx]; // see [RL14]
        next_rdata[PPDC_PF_DM]        = dm0[pin_idx];
        next_rdata[PPDC_PF_DM + 1]    = dm1[pin_idx];
        next_rdata[PPDC_PF_DM + 2]    = dm2[pin_idx];
        next_rdata[PPDC_PF_BYP]       = byp[pin_idx];
        next_rdata[PPDC_PF_BIE]       = bie[pin_idx];
        next_rdata[PPDC_PF_SLW]       = slw[pin_idx];
        next_rdata[PPDC_PF_REG]       = regout[pin_idx];
      end
    end else begin
      case (avs_address_i)
        PPDC_OFF_DATA:    next_rdata[7:0] = data_reg;
        PPDC_OFF_PSTATE:  next_rdata[7:0] = pin_state; // see [RL10]
        PPDC_OFF_DM0:     next_rdata[7:0] = dm0;
        PPDC_OFF_DM1:     next_rdata[7:0] = dm1;
        PPDC_OFF_DM2:     next_rdata[7:0] = dm2;
        PPDC_OFF_BYP:     next_rdata[7:0] = byp;
        PPDC_OFF_BIE:     next_rdata[7:0] = bie;
        PPDC_OFF_SLW:     next_rdata[7:0] = slw;
        PPDC_OFF_REGOUT:  next_rdata[7:0] = regout;
        PPDC_OFF_INTRISE: next_rdata[7:0] = int_rise;
        PPDC_OFF_INTFALL: next_rdata[7:0] = int_fall;
        PPDC_OFF_INTSTAT: next_rdata[7:0] = int_stat;
        PPDC_OFF_OESEL:   next_rdata      = oesel;
        default:          next_rdata      = 32'h0000_0000;
      endcase
    end
  end

  // Read data is captured in the wait cycle and holds through the answer.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && !ack) begin
      avs_readdata_o <= next_rdata;
    end
  end

endmodule

// [rtl/ppdc_pkg.sv]
package ppdc_pkg;

  // ------------------------------------------------------------------
  // Port geometry and bus
  // ------------------------------------------------------------------
  localparam int PPDC_PINS     = 8;
  localparam int PPDC_OE_LINES = 16;
  localparam int PPDC_OESEL_W  = 4;
  localparam int PPDC_AW       = 8;
  localparam int PPDC_DW       = 32;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] PPDC_OFF_DATA    = 8'h00;
  localparam logic [7:0] PPDC_OFF_PSTATE  = 8'h04;
  localparam logic [7:0] PPDC_OFF_DM0     = 8'h08;
  localparam logic [7:0] PPDC_OFF_DM1     = 8'h0c;
  localparam logic [7:0] PPDC_OFF_DM2     = 8'h10;
  localparam logic [7:0] PPDC_OFF_BYP     = 8'h14;
  localparam logic [7:0] PPDC_OFF_BIE     = 8'h18;
  localparam logic [7:0] PPDC_OFF_SLW     = 8'h1c;
  localparam logic [7:0] PPDC_OFF_REGOUT  = 8'h20;
  localparam logic [7:0] PPDC_OFF_INTRISE = 8'h24;
  localparam logic [7:0] PPDC_OFF_INTFALL = 8'h28;
  localparam logic [7:0] PPDC_OFF_INTSTAT = 8'h2c;
  localparam logic [7:0] PPDC_OFF_OESEL   = 8'h30;
  localparam logic [2:0] PPDC_PIN_PAGE    = 3'h2;

  // ------------------------------------------------------------------
  // Pin-form register field positions
  // ------------------------------------------------------------------
  localparam int PPDC_PF_DR  = 0;
  localparam int PPDC_PF_DM  = 1;
  localparam int PPDC_PF_BYP = 4;
  localparam int PPDC_PF_BIE = 5;
  localparam int PPDC_PF_SLW = 6;
  localparam int PPDC_PF_REG = 7;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0]  PPDC_RST_BYTE  = 8'h00;
  localparam logic [7:0]  PPDC_RST_DM    = 8'h00;
  localparam logic [31:0] PPDC_RST_OESEL = 32'h0000_0000;

  // ------------------------------------------------------------------
  // Drive modes
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    PPDC_HIZ_ANALOG  = 3'b000,
    PPDC_HIZ_DIGITAL = 3'b001,
    PPDC_RES_UP      = 3'b010,
    PPDC_RES_DOWN    = 3'b011,
    PPDC_OD_LOW      = 3'b100,
    PPDC_OD_HIGH     = 3'b101,
    PPDC_STRONG      = 3'b110,
    PPDC_RES_BOTH    = 3'b111
  } ppdc_mode_t;

  // True for the three modes that place a resistor in series.
  function automatic logic ppdc_is_resistive(input logic [2:0] mode);
    return (mode == PPDC_RES_UP) || (mode == PPDC_RES_DOWN) || (mode == PPDC_RES_BOTH);
  endfunction

endpackage

// [rtl/ppdc_pin_drive.sv]
`timescale 1ns/1ns
module ppdc_pin_drive
  import ppdc_pkg::*;
(
  input  wire logic [2:0] mode_i,
  input  wire logic       data_i,
  input  wire logic       bie_i,
  input  wire logic       oe_i,
  input  wire logic       special_i,
  input  wire logic       regout_i,
  input  wire logic       xcvr_i,
  output logic            drive_hi_o,
  output logic            drive_lo_o,
  output logic            pull_up_o,
  output logic            pull_dn_o,
  output logic            in_en_o
);

  // ------------------------------------------------------------------
  // Effective mode
  // ------------------------------------------------------------------
  logic [2:0] eff;
  logic       no_res;

  // Bidirectional pins fall back to digital high impedance while the routed
  // output enable is low; analog pins are never touched by it.
  always_comb begin
    eff = mode_i;
    if (bie_i && !oe_i && mode_i != PPDC_HIZ_ANALOG) begin
      eff = PPDC_HIZ_DIGITAL; // see [RL19]
    end
    if (xcvr_i && eff != PPDC_HIZ_ANALOG && eff != PPDC_HIZ_DIGITAL) begin
      eff = PPDC_STRONG; // see [RL17]
    end
  end

  // A regulated special pin cannot offer its resistors.
  assign no_res  = special_i & regout_i; // see [RL8]
  assign in_en_o = (mode_i != PPDC_HIZ_ANALOG); // see [RL18]

  // ------------------------------------------------------------------
  // Mode and data decode into the four pad controls
  // ------------------------------------------------------------------
  always_comb begin
    drive_hi_o = 1'b0;
    drive_lo_o = 1'b0;
    pull_up_o  = 1'b0;
    pull_dn_o  = 1'b0;
    case (eff) // see [RL1] see [RL20]
      PPDC_HIZ_ANALOG, PPDC_HIZ_DIGITAL: begin
        drive_hi_o = 1'b0; // see [RL2]
      end
      PPDC_RES_UP: begin
        pull_up_o  = data_i & ~no_res; // see [RL3]
        drive_lo_o = ~data_i;
      end
      PPDC_RES_DOWN: begin
        drive_hi_o = data_i; // see [RL3]
        pull_dn_o  = ~data_i & ~no_res;
      end
      PPDC_OD_LOW: begin
        drive_lo_o = ~data_i; // see [RL4]
      end
      PPDC_OD_HIGH: begin
        drive_hi_o = data_i; // see [RL5]
      end
      PPDC_STRONG: begin
        drive_hi_o = data_i; // see [RL6]
        drive_lo_o = ~data_i;
      end
      PPDC_RES_BOTH: begin
        pull_up_o = data_i & ~no_res; // see [RL7]
        pull_dn_o = ~data_i & ~no_res;
      end
      default: begin
        drive_hi_o = 1'b0;
      end
    endcase
  end

endmodule

// [dv/ppdc_top_chk.sv]
`timescale 1ns/1ns
module ppdc_top_chk
  import ppdc_pkg::*;
#(
  parameter int N_PINS = PPDC_PINS
)(
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  input  wire logic [PPDC_AW-1:0] avs_address_i,
  input  wire logic               avs_read_i,
  input  wire logic               avs_write_i,
  input  wire logic [PPDC_DW-1:0] avs_readdata_o,
  input  wire logic               avs_waitrequest_o,
  input  wire logic [N_PINS-1:0]  pad_oe_o,
  input  wire logic [N_PINS-1:0]  pad_pull_up_o,
  input  wire logic [N_PINS-1:0]  pad_pull_dn_o,
  input  wire logic [N_PINS-1:0]  pad_slow_o,
  input  wire logic [N_PINS-1:0]  dsi_in_o,
  input  wire logic               irq_o
);
  // ----------------------------------------------------------------
  // Bus and pad relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // Any request in flight; the master never raises both at once.
  logic req;
  assign req = avs_read_i | avs_write_i;

  property p_first_wait; req && !$past(req) |-> avs_waitrequest_o; endproperty
  a_first_wait: assert property (p_first_wait) else $error("request accepted without a wait cycle");
  property p_one_wait; req && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
  a_one_wait: assert property (p_one_wait) else $error("more than one wait cycle");
  property p_pstate;
    avs_read_i && avs_waitrequest_o && avs_address_i == PPDC_OFF_PSTATE |=> avs_readdata_o == PPDC_DW'($past(dsi_in_o));
  endproperty
  a_pstate: assert property (p_pstate) else $error("pin state read differs from pin state");
  property p_unmapped; avs_read_i && avs_waitrequest_o && avs_address_i == 8'h3c |=> avs_readdata_o == '0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_oe_pull; (pad_oe_o & (pad_pull_up_o | pad_pull_dn_o)) == '0; endproperty
  a_oe_pull: assert property (p_oe_pull) else $error("strong drive and resistor on one pin");
  property p_up_dn; (pad_pull_up_o & pad_pull_dn_o) == '0; endproperty
  a_up_dn: assert property (p_up_dn) else $error("pull-up and pull-down together");
  property p_slow; (pad_slow_o & ~pad_oe_o) == '0; endproperty
  a_slow: assert property (p_slow) else $error("slow slew on an undriven pin");
  property p_irq_hold;
    $fell(irq_o) |-> $past(avs_write_i && !avs_waitrequest_o && avs_address_i == PPDC_OFF_INTSTAT);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without a status clear");
endmodule

// [dv/ppdc_pin_partner.sv]
`timescale 1ns/1ns
module ppdc_pin_partner
  import ppdc_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic [PPDC_PINS-1:0] pad_out_i,
  input  wire logic [PPDC_PINS-1:0] pad_oe_i,
  input  wire logic [PPDC_PINS-1:0] pad_pull_up_i,
  input  wire logic [PPDC_PINS-1:0] pad_pull_dn_i,
  input  wire logic [PPDC_PINS-1:0] ext_en_i,
  input  wire logic [PPDC_PINS-1:0] ext_val_i,
  output logic      [PPDC_PINS-1:0] pin_lvl_o
);
  logic [PPDC_PINS-1:0] float_pat = '0;

  // A floating pin has no defined level, so it wanders every cycle.
  always_ff @(posedge clk_i) begin
    float_pat <= ~float_pat;
  end

  // Strong drive wins, then an external driver, then a resistor.
  always_comb begin
    for (int i = 0; i < PPDC_PINS; i++) begin
      pin_lvl_o[i] = pad_oe_i[i] ? pad_out_i[i] : ext_en_i[i] ? ext_val_i[i] :
                     pad_pull_up_i[i] ? 1'b1 : pad_pull_dn_i[i] ? 1'b0 : float_pat[i];
    end
  end
endmodule

// [dv/port_pin_drive_control_test.sv]
`timescale 1ns/1ns
module port_pin_drive_control_test
  import ppdc_pkg::*;
;
  logic        clk_i, rst_b_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o;
  logic [7:0]  avs_address_i, pad_in_i, pad_out_o, pad_oe_o, pad_pull_up_o, pad_pull_dn_o;
  logic [7:0]  pad_slow_o, dsi_out_i, dsi_in_o, ext_en, ext_val;
  logic [15:0] oe_bus_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  int          miscompares = 0;
  int          n_checks = 0;
  int          cycles = 0;

  ppdc_top #(.RESET_DM1(8'h01), .SPECIAL_MSK(8'h80)) ppdc_top_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o),
    .pad_pull_up_o(pad_pull_up_o), .pad_pull_dn_o(pad_pull_dn_o), .pad_slow_o(pad_slow_o),
    .dsi_out_i(dsi_out_i), .oe_bus_i(oe_bus_i), .dsi_in_o(dsi_in_o), .irq_o(irq_o));

  ppdc_pin_partner ppdc_pin_partner_inst (
    .clk_i(clk_i), .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o), .pad_pull_up_i(pad_pull_up_o),
    .pad_pull_dn_i(pad_pull_dn_o), .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_lvl_o(pad_in_i));

  // ----------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // A hung handshake would otherwise stall the run forever.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Holds the request until waitrequest is seen low, then idles one cycle.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= wr;
    avs_read_i      <= ~wr;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input string what, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, exp, q);
  endtask

  // Pads packed as strong enable, driven value, pull-up, pull-down.
  function automatic logic [31:0] expv(input int m, input logic d);
    logic [3:0] b;
    case (m)
      2: b = d ? 4'h2 : 4'h8;
      3: b = d ? 4'hc : 4'h1;
      4: b = d ? 4'h0 : 4'h8;
      5: b = d ? 4'hc : 4'h0;
      6: b = {1'b1, d, 2'h0};
      7: b = {2'h0, d, ~d};
      default: b = 4'h0;
    endcase
    return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b_i = 1'b0; avs_read_i = 1'b0; avs_write_i = 1'b0; avs_address_i = 8'h00; avs_writedata_i = 32'h0;
    dsi_out_i = 8'ha5; oe_bus_i = 16'h0000; ext_en = 8'h00; ext_val = 8'h00;
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk("reset pads", 32'h0100_0000, {pad_oe_o, pad_out_o & pad_oe_o, pad_pull_up_o, pad_pull_dn_o});
    @(posedge clk_i);
    rd(PPDC_OFF_DM1, "reset mode", 32'h01);
    $display("reset state test done");
    for (int m = 0; m < 8; m++) begin
      for (int d = 0; d < 2; d++) begin
        wr(PPDC_OFF_DM0, {24'h0, {8{m[0]}}});
        wr(PPDC_OFF_DM1, {24'h0, {8{m[1]}}});
        wr(PPDC_OFF_DM2, {24'h0, {8{m[2]}}});
        wr(PPDC_OFF_DATA, {24'h0, {8{d[0]}}});
        @(negedge clk_i);
        chk("pads", expv(m, d[0]), {pad_oe_o, pad_out_o & pad_oe_o, pad_pull_up_o, pad_pull_dn_o});
        @(posedge clk_i);
      end
    end
    wr(PPDC_OFF_REGOUT, 32'hff);
    @(negedge clk_i);
    chk("regulated pull", 32'h7f, pad_pull_up_o);
    @(posedge clk_i);
    $display("drive mode table test done");
    wr(PPDC_OFF_DM0, 32'h00);
    wr(PPDC_OFF_DATA, 32'h00);
    wr(PPDC_OFF_BYP, 32'hff);
    wr(PPDC_OFF_SLW, 32'hff);
    @(negedge clk_i);
    chk("bypass out", 32'ha5, pad_out_o);
    chk("slow strong", 32'hff, pad_slow_o);
    @(posedge clk_i);
    wr(PPDC_OFF_BYP, 32'h00);
    wr(PPDC_OFF_BIE, 32'h01);
    @(negedge clk_i);
    chk("oe line low", 32'hfe, pad_oe_o);
    @(posedge clk_i);
    oe_bus_i <= 16'h0001;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk("oe line high", 32'hff, pad_oe_o);
    @(posedge clk_i);
    wr(PPDC_OFF_BIE, 32'h00);
    wr(8'h4c, 32'h0b);
    rd(PPDC_OFF_DM0, "port form dm0", 32'h08);
    rd(PPDC_OFF_DM1, "port form dm1", 32'hf7);
    rd(8'h4c, "pin form", 32'h0b);
    rd(8'h3c, "unmapped", 32'h0);
    $display("port and pin form test done");
    wr(PPDC_OFF_DM0, 32'hff);
    wr(PPDC_OFF_DM1, 32'h00);
    wr(PPDC_OFF_DM2, 32'h00);
    ext_en <= 8'hff;
    wr(PPDC_OFF_INTRISE, 32'h05);
    wr(PPDC_OFF_INTFALL, 32'h06);
    wr(PPDC_OFF_INTSTAT, 32'hff);
    ext_val <= 8'h07;
    repeat (3) @(posedge clk_i);
    rd(PPDC_OFF_PSTATE, "pin state", 32'h07);
    rd(PPDC_OFF_INTSTAT, "rise status", 32'h05);
    chk("irq set", 32'h1, {31'h0, irq_o});
    wr(PPDC_OFF_INTSTAT, 32'h05);
    @(negedge clk_i);
    chk("irq clear", 32'h0, {31'h0, irq_o});
    @(posedge clk_i);
    ext_val <= 8'h00;
    repeat (3) @(posedge clk_i);
    rd(PPDC_OFF_INTSTAT, "fall status", 32'h06);
    wr(PPDC_OFF_PSTATE, 32'hff);
    rd(PPDC_OFF_PSTATE, "pin state kept", 32'h00);
    wr(PPDC_OFF_DM0, 32'hfe);
    ext_val <= 8'h01;
    repeat (3) @(posedge clk_i);
    rd(PPDC_OFF_PSTATE, "analog pin", 32'h00);
    rd(PPDC_OFF_INTSTAT, "analog no edge", 32'h06);
    $display("input and interrupt test done");
    wrap_up();
  end
endmodule

bind ppdc_top ppdc_top_chk #(.N_PINS(N_PINS)) ppdc_top_chk_inst (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .pad_oe_o(pad_oe_o), .pad_pull_up_o(pad_pull_up_o), .pad_pull_dn_o(pad_pull_dn_o),
  .pad_slow_o(pad_slow_o), .dsi_in_o(dsi_in_o), .irq_o(irq_o));
